/* hdl/cmd_handler_pkg.sv */
// Purpose: shared constants for the detector board command handler.
// Assumes: commands and replies arrive on the system clock from relay logic.
// Notes: command codes are compared on the low identifier bits only.
package cmd_handler_pkg;
  // command codes (low identifier bits)
  localparam int CODE_MSB = 11;
  localparam logic [11:0] CMD_MASK_WR = 12'h009;
  localparam logic [11:0] CMD_MASK_RD = 12'h00a;
  localparam logic [11:0] CMD_SRAM_WR = 12'h00b;
  localparam logic [11:0] CMD_SRAM_RD = 12'h00c;
  localparam logic [11:0] CMD_SRAM_CLR = 12'h00d;
  localparam logic [11:0] CMD_SYS_RST = 12'h00f;
  localparam logic [11:0] CMD_NODE = 12'h010;
  localparam logic [11:0] CMD_VERSION = 12'h011;
  localparam logic [11:0] CMD_TDC_WR = 12'h101;
  localparam logic [11:0] CMD_TDC_RD = 12'h102;
  localparam logic [11:0] CMD_ADC_RST = 12'h103;
  localparam logic [11:0] CMD_ADC_WR = 12'h104;
  localparam logic [11:0] CMD_DAC_RST = 12'h105;
  localparam logic [15:0] RSP_FLAG = 16'h8000;
  // node type codes
  localparam logic [3:0] NODE_CRATE_CONTROLLER = 4'h0;
  localparam logic [3:0] NODE_MULTIPLEXER_BOARD = 4'h1;
  localparam logic [3:0] NODE_DETECTOR_UNIT_CONTROLLER = 4'h2;
  localparam logic [3:0] NODE_DETECTOR_BOARD = 4'h3;
  localparam logic [3:0] NODE_COMBINED_UNIT_CRATE_CONTROLLER = 4'h4;
  // time_to_digital_converter command codes
  localparam int TDC_CMD_MSB = 7;
  localparam logic [7:0] TDC_CMD_RESET = 8'h80;
  localparam logic [7:0] TDC_CMD_CALIBRATE = 8'h02;
  localparam logic [7:0] TDC_CMD_RUN = 8'h04;
  // adc register write payload fields
  localparam int ADC_DATA_MSB = 15;
  localparam int ADC_ADDR_MSB = 25;
  localparam int ADC_ADDR_LSB = 18;
  localparam int ADC_CS_BIT = 27;
  localparam int ADC_BCAST_BIT = 31;
  localparam logic [7:0] ADC_GAIN_LOW_REG = 8'h2a;
  localparam logic [7:0] ADC_GAIN_HIGH_REG = 8'h2b;
  // adc default table, entry 0 in the low slice
  localparam int ADC_DEF_N = 3;
  localparam logic [1:0] ADC_DEF_LAST = 2'h2;
  localparam logic [23:0] ADC_DEF_ADDR = {ADC_GAIN_HIGH_REG, ADC_GAIN_LOW_REG, 8'h00};
  localparam logic [47:0] ADC_DEF_DATA = {16'h0000, 16'h0000, 16'h0001};
  // register reset values
  localparam logic [31:0] MASK_RESET = 32'hffffffff;
  localparam logic [7:0] TDC_RESET = 8'h00;
  // version word layout
  localparam int VER_PAD = 12;
  // external sram
  localparam int SRAM_AW = 16;
  localparam logic [1:0] SRAM_OP_WR = 2'h0;
  localparam logic [1:0] SRAM_OP_RD = 2'h1;
  localparam logic [1:0] SRAM_OP_CLR = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SRAM = 5'b00010,
    ST_ADC = 5'b00100,
    ST_DAC = 5'b01000,
    ST_REPLY = 5'b10000
  } hs_state_t;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_ACC = 3'b010,
    SQ_DONE = 3'b100
  } sq_state_t;
endpackage : cmd_handler_pkg

/* hdl/sram_sequencer.sv */
// Purpose: external sram access with auto-increment address and clear sweep.
// Assumes: sram controller on the same clock, ack is a one-cycle pulse.
// Notes: a clear walks every address once and leaves the address at zero.
`timescale 1ns/1ps
`default_nettype none
module sram_sequencer (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] i_addr,
  input wire logic i_addr_clear,
  output logic o_done,
  output logic [31:0] o_rdata,
  output logic o_sram_req,
  output logic o_sram_we,
  output logic [cmd_handler_pkg::SRAM_AW-1:0] o_sram_addr,
  output logic [31:0] o_sram_wdata,
  input wire logic i_sram_ack,
  input wire logic [31:0] i_sram_rdata
);
  typedef struct packed {
    cmd_handler_pkg::sq_state_t st;
    logic [cmd_handler_pkg::SRAM_AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic we;
    logic clr;
  } sq_t;
  sq_t q, d;

  // next state: one access per command, clear repeats until the top address
  always_comb begin
    d = q;
    case (q.st)
      cmd_handler_pkg::SQ_IDLE: begin
        if (i_start) begin
          d.st = cmd_handler_pkg::SQ_ACC;
          d.clr = (i_op == cmd_handler_pkg::SRAM_OP_CLR);
          d.we = (i_op != cmd_handler_pkg::SRAM_OP_RD);
          if (i_op == cmd_handler_pkg::SRAM_OP_WR) begin
            d.wdata = i_wdata;
          end else if (i_op == cmd_handler_pkg::SRAM_OP_RD) begin
            d.addr = i_addr[cmd_handler_pkg::SRAM_AW-1:0];
          end else begin
            d.wdata = '0;
            d.addr = '0;
          end
        end else if (i_addr_clear) begin
          d.addr = '0;
        end
      end
      cmd_handler_pkg::SQ_ACC: begin
        if (i_sram_ack) begin
          d.addr = q.addr + 1'b1;
          if (!q.we) begin
            d.rdata = i_sram_rdata;
          end
          if (!q.clr || (&q.addr)) begin
            d.st = cmd_handler_pkg::SQ_DONE;
          end
        end
      end
      cmd_handler_pkg::SQ_DONE: d.st = cmd_handler_pkg::SQ_IDLE;
      default: d = '{st: cmd_handler_pkg::SQ_IDLE, default: '0};
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '{st: cmd_handler_pkg::SQ_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_sram_req = (q.st == cmd_handler_pkg::SQ_ACC);
  assign o_sram_we = q.we;
  assign o_sram_addr = q.addr;
  assign o_sram_wdata = q.wdata;
  assign o_done = (q.st == cmd_handler_pkg::SQ_DONE);
  assign o_rdata = q.rdata;

  property p_sram_incr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_sram_req && i_sram_ack) |=> (o_sram_addr == $past(o_sram_addr) + 1'b1);
  endproperty
  a_sram_incr: assert property (p_sram_incr) else $error("sram address not advanced");
  property p_sram_rd_addr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.st == cmd_handler_pkg::SQ_IDLE && i_start && i_op == cmd_handler_pkg::SRAM_OP_RD)
      |=> (o_sram_req && !o_sram_we && o_sram_addr == $past(i_addr[15:0]));
  endproperty
  a_sram_rd_addr: assert property (p_sram_rd_addr) else $error("sram read address wrong");
  property p_sram_clr_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_sram_req && q.clr) |-> (o_sram_we && o_sram_wdata == 32'h0);
  endproperty
  a_sram_clr_zero: assert property (p_sram_clr_zero) else $error("clear wrote nonzero");
endmodule : sram_sequencer
`default_nettype wire

/* hdl/detector_board_command_handler.sv */
// Purpose: decode relayed commands and answer each with one reply.
// Assumes: command and reply ports are driven by logic on the same clock.
// Notes: the handler takes one command at a time; ready stays low until the
//   reply has been accepted, so a long command blocks this node only.
`timescale 1ns/1ps
`default_nettype none
module detector_board_command_handler #(
  parameter logic [3:0] NODE_TYPE = cmd_handler_pkg::NODE_DETECTOR_BOARD,
  parameter logic [7:0] VER_MAJOR = 8'h01, // arbitrary value
  parameter logic [7:0] VER_MINOR = 8'h00, // arbitrary value
  parameter logic [3:0] VER_SUBMINOR = 4'h0 // arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // command in
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [15:0] i_cmd_id,
  input wire logic [15:0] i_cmd_dest,
  input wire logic [31:0] i_cmd_payload,
  // reply out
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output logic [15:0] o_rsp_id,
  output logic [15:0] o_rsp_dest,
  output logic [31:0] o_rsp_payload,
  // firmware configuration
  output logic [31:0] o_trigger_enable,
  output logic [7:0] o_tdc_control,
  output logic o_tdc_strobe,
  // adc register write port
  output logic o_adc_wr_req,
  output logic [7:0] o_adc_wr_addr,
  output logic [15:0] o_adc_wr_data,
  output logic [1:0] o_adc_chip_en,
  input wire logic i_adc_wr_ack,
  // dac default programming port
  output logic o_dac_defaults_req,
  input wire logic i_dac_defaults_done,
  // external sram
  output logic o_sram_req,
  output logic o_sram_we,
  output logic [cmd_handler_pkg::SRAM_AW-1:0] o_sram_addr,
  output logic [31:0] o_sram_wdata,
  input wire logic i_sram_ack,
  input wire logic [31:0] i_sram_rdata
);
  typedef struct packed {
    cmd_handler_pkg::hs_state_t st;
    logic [31:0] mask;
    logic [7:0] time_to_digital_converter;
    logic tdc_stb;
    logic [15:0] rsp_id;
    logic [15:0] rsp_dest;
    logic [31:0] rsp_pay;
    logic [1:0] sram_op;
    logic sram_go;
    logic sram_addr_clr;
    logic [7:0] adc_addr;
    logic [15:0] adc_data;
    logic [1:0] adc_cs;
    logic [1:0] adc_idx;
    logic adc_seq;
    logic then_dac;
  } hs_t;
  hs_t q, d;
  logic [11:0] code;
  logic sram_done;
  logic [31:0] sram_rdata;

  assign code = i_cmd_id[cmd_handler_pkg::CODE_MSB:0];

  // default adc table entry selected by index; all chips take the defaults
  function automatic hs_t load_adc_default(input hs_t s, input logic [1:0] idx);
    hs_t r;
    r = s;
    r.adc_idx = idx;
    r.adc_addr = cmd_handler_pkg::ADC_DEF_ADDR[8*int'(idx) +: 8];
    r.adc_data = cmd_handler_pkg::ADC_DEF_DATA[16*int'(idx) +: 16];
    r.adc_cs = 2'h3;
    r.adc_seq = 1'b1;
    return r;
  endfunction : load_adc_default

  // command decode and sequencing
  always_comb begin
    d = q;
    d.tdc_stb = 1'b0;
    d.sram_go = 1'b0;
    d.sram_addr_clr = 1'b0;
    case (q.st)
      cmd_handler_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          d.rsp_id = i_cmd_id | cmd_handler_pkg::RSP_FLAG;
          d.rsp_dest = i_cmd_dest;
          d.rsp_pay = '0;
          d.st = cmd_handler_pkg::ST_REPLY;
          d.then_dac = 1'b0;
          case (code)
            cmd_handler_pkg::CMD_MASK_WR: begin
              d.mask = i_cmd_payload;
              d.rsp_pay = i_cmd_payload;
            end
            cmd_handler_pkg::CMD_MASK_RD: d.rsp_pay = q.mask;
            cmd_handler_pkg::CMD_SRAM_WR: begin
              d.sram_op = cmd_handler_pkg::SRAM_OP_WR;
              d.rsp_pay = i_cmd_payload; // data word, echoed in the reply
              d.sram_go = 1'b1;
              d.st = cmd_handler_pkg::ST_SRAM;
            end
            cmd_handler_pkg::CMD_SRAM_RD: begin
              d.sram_op = cmd_handler_pkg::SRAM_OP_RD;
              d.rsp_pay = i_cmd_payload; // address word for the sequencer
              d.sram_go = 1'b1;
              d.st = cmd_handler_pkg::ST_SRAM;
            end
            cmd_handler_pkg::CMD_SRAM_CLR: begin
              d.sram_op = cmd_handler_pkg::SRAM_OP_CLR;
              d.sram_go = 1'b1;
              d.st = cmd_handler_pkg::ST_SRAM;
            end
            cmd_handler_pkg::CMD_SYS_RST: begin
              // firmware registers now, then adc and dac defaults in turn
              d.mask = cmd_handler_pkg::MASK_RESET;
              d.time_to_digital_converter = cmd_handler_pkg::TDC_RESET;
              d.sram_addr_clr = 1'b1;
              d = load_adc_default(d, 2'h0);
              d.then_dac = 1'b1;
              d.st = cmd_handler_pkg::ST_ADC;
            end
            cmd_handler_pkg::CMD_NODE: d.rsp_pay = 32'(NODE_TYPE);
            cmd_handler_pkg::CMD_VERSION: begin
              d.rsp_pay = {{cmd_handler_pkg::VER_PAD{1'b0}}, VER_MAJOR, VER_MINOR,
                           VER_SUBMINOR};
            end
            cmd_handler_pkg::CMD_TDC_WR: begin
              d.time_to_digital_converter = i_cmd_payload[cmd_handler_pkg::TDC_CMD_MSB:0];
              d.tdc_stb = 1'b1;
              d.rsp_pay = 32'(i_cmd_payload[cmd_handler_pkg::TDC_CMD_MSB:0]);
            end
            cmd_handler_pkg::CMD_TDC_RD: d.rsp_pay = 32'(q.time_to_digital_converter);
            cmd_handler_pkg::CMD_ADC_RST: begin
              d = load_adc_default(d, 2'h0);
              d.st = cmd_handler_pkg::ST_ADC;
            end
            cmd_handler_pkg::CMD_ADC_WR: begin
              // gain writes are ordinary register writes, four channels each
              d.adc_data = i_cmd_payload[cmd_handler_pkg::ADC_DATA_MSB:0];
              d.adc_addr = i_cmd_payload[cmd_handler_pkg::ADC_ADDR_MSB:
                                         cmd_handler_pkg::ADC_ADDR_LSB];
              if (i_cmd_payload[cmd_handler_pkg::ADC_BCAST_BIT]) begin
                d.adc_cs = 2'h3;
              end else if (i_cmd_payload[cmd_handler_pkg::ADC_CS_BIT]) begin
                d.adc_cs = 2'h2;
              end else begin
                d.adc_cs = 2'h1;
              end
              d.adc_seq = 1'b0;
              d.rsp_pay = i_cmd_payload;
              d.st = cmd_handler_pkg::ST_ADC;
            end
            cmd_handler_pkg::CMD_DAC_RST: d.st = cmd_handler_pkg::ST_DAC;
            default: d.rsp_pay = '0;
          endcase
        end
      end
      cmd_handler_pkg::ST_SRAM: begin
        if (sram_done) begin
          d.st = cmd_handler_pkg::ST_REPLY;
          if (q.sram_op == cmd_handler_pkg::SRAM_OP_RD) begin
            d.rsp_pay = sram_rdata;
          end else if (q.sram_op == cmd_handler_pkg::SRAM_OP_WR) begin
            d.rsp_pay = q.rsp_pay;
          end else begin
            d.rsp_pay = '0;
          end
        end
      end
      cmd_handler_pkg::ST_ADC: begin
        if (i_adc_wr_ack) begin
          if (q.adc_seq && q.adc_idx != cmd_handler_pkg::ADC_DEF_LAST) begin
            d = load_adc_default(q, q.adc_idx + 1'b1);
          end else if (q.then_dac) begin
            d.st = cmd_handler_pkg::ST_DAC;
          end else begin
            d.st = cmd_handler_pkg::ST_REPLY;
          end
        end
      end
      cmd_handler_pkg::ST_DAC: begin
        if (i_dac_defaults_done) begin
          d.st = cmd_handler_pkg::ST_REPLY;
        end
      end
      cmd_handler_pkg::ST_REPLY: begin
        if (i_rsp_ready) begin
          d.st = cmd_handler_pkg::ST_IDLE;
        end
      end
      default: d.st = cmd_handler_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '{st: cmd_handler_pkg::ST_IDLE, mask: cmd_handler_pkg::MASK_RESET,
             time_to_digital_converter: cmd_handler_pkg::TDC_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  // sram sequencer owns the address counter; only idle accepts a start
  sram_sequencer u_sram (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_start(q.sram_go),
    .i_op(q.sram_op),
    .i_wdata(q.rsp_pay),
    .i_addr(q.rsp_pay),
    .i_addr_clear(q.sram_addr_clr),
    .o_done(sram_done),
    .o_rdata(sram_rdata),
    .o_sram_req(o_sram_req),
    .o_sram_we(o_sram_we),
    .o_sram_addr(o_sram_addr),
    .o_sram_wdata(o_sram_wdata),
    .i_sram_ack(i_sram_ack),
    .i_sram_rdata(i_sram_rdata)
  );

  // a busy node takes no new command until its reply is gone
  assign o_cmd_ready = (q.st == cmd_handler_pkg::ST_IDLE);
  assign o_rsp_valid = (q.st == cmd_handler_pkg::ST_REPLY);
  assign o_rsp_id = q.rsp_id;
  assign o_rsp_dest = q.rsp_dest;
  assign o_rsp_payload = q.rsp_pay;
  assign o_trigger_enable = q.mask;
  assign o_tdc_control = q.time_to_digital_converter;
  assign o_tdc_strobe = q.tdc_stb;
  assign o_adc_wr_req = (q.st == cmd_handler_pkg::ST_ADC);
  assign o_adc_wr_addr = q.adc_addr;
  assign o_adc_wr_data = q.adc_data;
  assign o_adc_chip_en = q.adc_cs;
  assign o_dac_defaults_req = (q.st == cmd_handler_pkg::ST_DAC);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_take(logic [11:0] c);
    o_cmd_ready && i_cmd_valid && i_cmd_id[11:0] == c;
  endsequence
  property p_mask_wr;
    s_take(cmd_handler_pkg::CMD_MASK_WR) |=> o_trigger_enable == $past(i_cmd_payload);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not stored");
  property p_mask_rd;
    s_take(cmd_handler_pkg::CMD_MASK_RD) |=> o_rsp_valid && o_rsp_payload == o_trigger_enable;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
  property p_sys_rst;
    s_take(cmd_handler_pkg::CMD_SYS_RST) |=> o_trigger_enable == 32'hffffffff
      && o_tdc_control == 8'h00 && o_adc_wr_req;
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("system reset incomplete");
  property p_node;
    s_take(cmd_handler_pkg::CMD_NODE) |=> o_rsp_payload == 32'(NODE_TYPE);
  endproperty
  a_node: assert property (p_node) else $error("node type wrong");
  property p_version;
    s_take(cmd_handler_pkg::CMD_VERSION) |=> o_rsp_payload[19:12] == VER_MAJOR
      && o_rsp_payload[11:4] == VER_MINOR && o_rsp_payload[3:0] == VER_SUBMINOR;
  endproperty
  a_version: assert property (p_version) else $error("version word wrong");
  property p_tdc_wr;
    s_take(cmd_handler_pkg::CMD_TDC_WR) |=> o_tdc_strobe && o_tdc_control == $past(i_cmd_payload[7:0]);
  endproperty
  a_tdc_wr: assert property (p_tdc_wr) else $error("tdc command not taken");
  property p_adc_bcast;
    (s_take(cmd_handler_pkg::CMD_ADC_WR) ##0 i_cmd_payload[31])
      |=> o_adc_wr_req && o_adc_chip_en == 2'h3 && o_adc_wr_addr == $past(i_cmd_payload[25:18]);
  endproperty
  a_adc_bcast: assert property (p_adc_bcast) else $error("broadcast adc write");
  property p_adc_rst;
    s_take(cmd_handler_pkg::CMD_ADC_RST) |=> o_adc_wr_req && o_adc_wr_addr == 8'h00
      && o_adc_chip_en == 2'h3;
  endproperty
  a_adc_rst: assert property (p_adc_rst) else $error("adc defaults not started");
  sequence s_dac_finish;
    o_dac_defaults_req && i_dac_defaults_done;
  endsequence
  property p_dac_reply;
    s_dac_finish |=> o_rsp_valid && !o_cmd_ready;
  endproperty
  a_dac_reply: assert property (p_dac_reply) else $error("dac reset not answered");
  property p_reply_id;
    o_rsp_valid |-> o_rsp_id[15] && !o_cmd_ready;
  endproperty
  a_reply_id: assert property (p_reply_id) else $error("reply id flag missing");
  // handshake and field checks
  property p_dest;
    (o_cmd_ready && i_cmd_valid) |=> o_rsp_dest == $past(i_cmd_dest);
  endproperty
  a_dest: assert property (p_dest) else $error("reply dest wrong");
  property p_busy;
    (o_cmd_ready && i_cmd_valid) |=> !o_cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_tdc_rd;
    s_take(cmd_handler_pkg::CMD_TDC_RD) |=> o_rsp_payload == 32'(o_tdc_control);
  endproperty
  a_tdc_rd: assert property (p_tdc_rd) else $error("tdc read wrong");
  // one cycle wide, so the converter sees each command once
  property p_tdc_pulse;
    o_tdc_strobe |=> !o_tdc_strobe;
  endproperty
  a_tdc_pulse: assert property (p_tdc_pulse) else $error("tdc strobe too long");
  // without broadcast exactly one chip is enabled
  property p_adc_chip;
    (s_take(cmd_handler_pkg::CMD_ADC_WR) ##0 !i_cmd_payload[31])
      |=> o_adc_chip_en == {$past(i_cmd_payload[27]), !$past(i_cmd_payload[27])}
      && o_adc_wr_data == $past(i_cmd_payload[15:0]);
  endproperty
  a_adc_chip: assert property (p_adc_chip) else $error("adc chip select wrong");
  // the converter port must not move under a pending write
  property p_adc_hold;
    (o_adc_wr_req && !i_adc_wr_ack) |=> o_adc_wr_req && $stable(o_adc_wr_addr)
      && $stable(o_adc_wr_data) && $stable(o_adc_chip_en);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("adc write moved");
  // the data word reaches the sram two cycles after the take
  property p_sram_data;
    s_take(cmd_handler_pkg::CMD_SRAM_WR) |=> ##1 o_sram_req && o_sram_we
      && o_sram_wdata == $past(i_cmd_payload, 2);
  endproperty
  a_sram_data: assert property (p_sram_data) else $error("sram write data wrong");
  property p_mask_hold;
    !(o_cmd_ready && i_cmd_valid) |=> $stable(o_trigger_enable);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask moved");
endmodule : detector_board_command_handler
`default_nettype wire

/* test/periph_model.sv */
// Purpose: responder for the sram, adc and dac ports of the handler.
// Assumes: one access pending at a time; acks are one-cycle pulses.
// Notes: i_slow adds three wait cycles; idle sram data shows inverted last word.
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic i_sram_req,
  input wire logic i_sram_we,
  input wire logic [15:0] i_sram_addr,
  input wire logic [31:0] i_sram_wdata,
  output logic o_sram_ack,
  output logic [31:0] o_sram_rdata,
  input wire logic i_adc_req,
  input wire logic [7:0] i_adc_addr,
  input wire logic [15:0] i_adc_data,
  input wire logic [1:0] i_adc_en,
  output logic o_adc_ack,
  input wire logic i_dac_req,
  output logic o_dac_done
);
  logic [31:0] mem [0:255];
  logic [31:0] last_q = 32'h0;
  logic [1:0] wait_q = 2'h0;
  logic [25:0] adc_last = 26'h0; // chip enables, address, data
  int adc_cnt = 0;
  int dac_cnt = 0;
  initial begin
    o_sram_ack = 1'b0;
    o_adc_ack = 1'b0;
    o_dac_done = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end
  // a released data bus must not keep showing the last word
  assign o_sram_rdata = i_sram_req ? mem[i_sram_addr[7:0]] : ~last_q;
  // one shared wait counter; the pending request is acked once
  always @(posedge i_sys_clk) begin
    o_sram_ack <= 1'b0;
    o_adc_ack <= 1'b0;
    o_dac_done <= 1'b0;
    if ((i_sram_req | i_adc_req | i_dac_req) && !(o_sram_ack | o_adc_ack | o_dac_done)) begin
      if (wait_q == (i_slow ? 2'h3 : 2'h0)) begin
        wait_q <= 2'h0;
        o_sram_ack <= i_sram_req;
        o_adc_ack <= i_adc_req;
        o_dac_done <= i_dac_req;
        if (i_sram_req && i_sram_we) mem[i_sram_addr[7:0]] <= i_sram_wdata;
        if (i_sram_req) last_q <= o_sram_rdata;
        if (i_adc_req) adc_cnt <= adc_cnt + 1;
        if (i_adc_req) adc_last <= {i_adc_en, i_adc_addr, i_adc_data};
        if (i_dac_req) dac_cnt <= dac_cnt + 1;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : periph_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: self-checking bench for the command handler.
// Assumes: commands are offered one at a time and replies taken at once.
// Notes: sram clear is cut short by a reset, a full sweep would be far too long.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_id = 16'h0;
  logic [15:0] cmd_dest = 16'h0;
  logic [31:0] cmd_payload = 32'h0;
  logic rsp_ready = 1'b0;
  logic cmd_ready, rsp_valid, tdc_strobe, adc_req, adc_ack, dac_req, dac_done;
  logic sram_req, sram_we, sram_ack;
  logic [15:0] rsp_id, rsp_dest, sram_addr, r_id, r_dest;
  logic [31:0] rsp_payload, trig, sram_wdata, sram_rdata, r_pay;
  logic [7:0] time_to_digital_converter, adc_addr;
  logic [15:0] adc_data;
  logic [1:0] adc_en;
  int errors = 0;
  int total_checks = 0;
  int strobes = 0;
  always #25 sys_clk = ~sys_clk;
  // counts converter command strobes
  always @(posedge sys_clk) if (tdc_strobe === 1'b1) strobes <= strobes + 1;
  detector_board_command_handler u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_id(cmd_id),
    .i_cmd_dest(cmd_dest), .i_cmd_payload(cmd_payload), .o_rsp_valid(rsp_valid),
    .i_rsp_ready(rsp_ready), .o_rsp_id(rsp_id), .o_rsp_dest(rsp_dest),
    .o_rsp_payload(rsp_payload), .o_trigger_enable(trig), .o_tdc_control(time_to_digital_converter),
    .o_tdc_strobe(tdc_strobe), .o_adc_wr_req(adc_req), .o_adc_wr_addr(adc_addr),
    .o_adc_wr_data(adc_data), .o_adc_chip_en(adc_en), .i_adc_wr_ack(adc_ack),
    .o_dac_defaults_req(dac_req), .i_dac_defaults_done(dac_done),
    .o_sram_req(sram_req), .o_sram_we(sram_we), .o_sram_addr(sram_addr),
    .o_sram_wdata(sram_wdata), .i_sram_ack(sram_ack), .i_sram_rdata(sram_rdata));
  periph_model u_model (.i_sys_clk(sys_clk), .i_slow(slow), .i_sram_req(sram_req),
    .i_sram_we(sram_we), .i_sram_addr(sram_addr), .i_sram_wdata(sram_wdata),
    .o_sram_ack(sram_ack), .o_sram_rdata(sram_rdata), .i_adc_req(adc_req),
    .i_adc_addr(adc_addr), .i_adc_data(adc_data), .i_adc_en(adc_en),
    .o_adc_ack(adc_ack), .i_dac_req(dac_req), .o_dac_done(dac_done));
  task automatic results;
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // offer one command, hold it until taken, then take the reply
  task automatic cmd(input logic [15:0] id, input logic [15:0] ds, input logic [31:0] pl);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_id <= id;
    cmd_dest <= ds;
    cmd_payload <= pl;
    rsp_ready <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 900);
    cmd_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      if (cmd_ready !== 1'b0) chk("ready_busy", 32'h0, {31'h0, cmd_ready});
    end while (rsp_valid !== 1'b1 && n < 900);
    r_id = rsp_id;
    r_dest = rsp_dest;
    r_pay = rsp_payload;
    if (n >= 900) chk("timeout", 32'h0, 32'h1);
    if (n >= 900) results();
  endtask : cmd
  task automatic t_reset;
    chk("mask_rst", 32'hffffffff, trig);
    chk("tdc_rst", 32'h0, {24'h0, time_to_digital_converter});
  endtask : t_reset
  task automatic t_mask;
    cmd(16'h1009, 16'h8005, 32'h00000121);
    chk("rsp_id", 32'h9009, {16'h0, r_id});
    chk("rsp_dest", 32'h8005, {16'h0, r_dest});
    chk("mask", 32'h00000121, trig);
    cmd(16'h000a, 16'h0005, 32'hdeadfeed);
    chk("mask_rd", 32'h00000121, r_pay);
  endtask : t_mask
  // acquisition action is taken to be in its reset state throughout
  task automatic t_sram;
    slow <= 1'b1;
    cmd(16'h000b, 16'h0001, 32'h12345678);
    cmd(16'h000b, 16'h0001, 32'h9abcdef0);
    cmd(16'h000c, 16'h0001, 32'h0);
    chk("sram_rd", 32'h12345678, r_pay);
    cmd(16'h000b, 16'h0001, 32'h55aa55aa);
    chk("sram_inc", 32'h55aa55aa, u_model.mem[1]);
    chk("sram_wr0", 32'h12345678, u_model.mem[0]);
    slow <= 1'b0;
  endtask : t_sram
  // a clear is cut short by a reset; the first words are zero by then
  task automatic t_clear;
    cmd_valid <= 1'b1;
    cmd_id <= 16'h000d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk("clr_mem", 32'h0, u_model.mem[1]);
    chk("clr_busy", 32'h0, {31'h0, cmd_ready});
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("rst_ready", 32'h1, {31'h0, cmd_ready});
    chk("rst_mask", 32'hffffffff, trig);
  endtask : t_clear
  task automatic t_ident;
    cmd(16'h0010, 16'h0003, 32'hdeadfeed);
    chk("node", {28'h0, cmd_handler_pkg::NODE_DETECTOR_BOARD}, r_pay);
    cmd(16'h0011, 16'h0003, 32'h0);
    chk("version", 32'h00001000, r_pay);
  endtask : t_ident
  task automatic t_tdc;
    logic [7:0] c [3];
    int s;
    c = '{cmd_handler_pkg::TDC_CMD_RESET, 8'h02, 8'h04};
    s = strobes;
    foreach (c[i]) begin
      cmd(16'h0101, 16'h0005, {24'hdeadbe, c[i]});
      chk("tdc_wr", {24'h0, c[i]}, {24'h0, time_to_digital_converter});
      chk("tdc_wr_pay", {24'h0, c[i]}, r_pay);
      cmd(16'h0102, 16'h0005, 32'hdeadfeed);
      chk("tdc_rd", {24'h0, c[i]}, r_pay);
    end
    chk("tdc_stb", 32'd3, 32'(strobes - s));
  endtask : t_tdc
  task automatic t_adc;
    logic [31:0] p [3];
    logic [25:0] e [3];
    p = '{32'h00ac6666, 32'h88a88888, 32'h08a81234};
    e = '{{2'h1, 8'h2b, 16'h6666}, {2'h3, 8'h2a, 16'h8888}, {2'h2, 8'h2a, 16'h1234}};
    foreach (p[i]) begin
      cmd(16'h0104, 16'h0003, p[i]);
      chk("adc_wr", {6'h0, e[i]}, {6'h0, u_model.adc_last});
    end
  endtask : t_adc
  task automatic t_resets;
    int a;
    int d;
    a = u_model.adc_cnt;
    d = u_model.dac_cnt;
    cmd(16'h0103, 16'h0003, 32'hdeadfeed);
    chk("adc_rst_n", 32'd3, 32'(u_model.adc_cnt - a));
    chk("adc_rst_last", {6'h0, 2'h3, 8'h2b, 16'h0}, {6'h0, u_model.adc_last});
    cmd(16'h0105, 16'h0003, 32'h0);
    chk("dac_rst", 32'd1, 32'(u_model.dac_cnt - d));
    cmd(16'h0009, 16'h0003, 32'h0);
    cmd(16'h000f, 16'h8001, 32'h0);
    chk("sys_mask", 32'hffffffff, trig);
    chk("sys_tdc", 32'h0, {24'h0, time_to_digital_converter});
    chk("sys_dac", 32'd2, 32'(u_model.dac_cnt - d));
    chk("sys_id", 32'h800f, {16'h0, r_id});
  endtask : t_resets
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_mask();
    t_sram();
    t_clear();
    t_ident();
    t_tdc();
    t_adc();
    t_resets();
    results();
  end
endmodule : testbench
`default_nettype wire
